// >>> include/slpc_pkg.sv
// Package for the serial link status and PLL configuration register group.
// Assumes a byte-wide register port and one register clock for all users.
package slpc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_PLL = 4;

  localparam logic [15:0] OFS_LINK_STATUS = 16'h0107;
  localparam logic [15:0] OFS_REF_DIV = 16'h0108;
  localparam logic [15:0] OFS_PLL_MULT = 16'h0109;
  localparam logic [15:0] OFS_LINE_RATE = 16'h010a;

  localparam int BIT_OVERRUN = 7;
  localparam int BIT_LINK_UP = 6;
  localparam int BIT_SYNC_LEVEL = 5;
  localparam int BIT_REALIGNED = 4;
  localparam int BIT_CONSISTENT = 3;
  localparam int BIT_PLL_LOCKED = 2;

  localparam int REF_DIV_W = 6;
  localparam int RATE_W = 2;

  localparam logic [5:0] RST_REF_DIV = 6'h30;
  localparam logic [7:0] RST_PLL_MULT = 8'h14;
  localparam logic [1:0] RST_LINE_RATE = 2'h0;

  localparam logic [7:0] MULT_CODE_X4 = 8'h10;
  localparam logic [7:0] MULT_CODE_X5 = 8'h14;
  localparam logic [7:0] MULT_CODE_X8P25 = 8'h21;
  localparam logic [7:0] MULT_CODE_X10 = 8'h28;

  localparam logic [1:0] RATE_X4 = 2'h0;
  localparam logic [1:0] RATE_X2 = 2'h1;
  localparam logic [1:0] RATE_X1 = 2'h2;
  localparam logic [1:0] RATE_XHALF = 2'h3;

  localparam logic [2:0] SYSREF_ALIGN_MAX = 3'h7;
endpackage

// >>> hdl/slpc_cfg_decode.sv
// Registered decoder for the PLL divisor, multiplier and line-rate settings.
// Assumes the three settings come straight from configuration flip-flops.
`timescale 1ns/10ps
module slpc_cfg_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire logic [5:0] ref_div_i,
  input wire logic [7:0] mult_code_i,
  input wire logic [1:0] rate_i,
  output logic [7:0] mult_quarters_o,
  output logic [3:0] rate_halves_o,
  output logic cfg_legal_o
);
  function automatic logic div_legal(input logic [5:0] d);
    unique case (d)
      6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h0a,
      6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h28, 6'h30: div_legal = 1'b1;
      default: div_legal = 1'b0;
    endcase
  endfunction

  // The multiplier code is the ratio in quarter units, so a legal code passes through unchanged.
  function automatic logic [7:0] mult_decode(input logic [7:0] c);
    unique case (c)
      slpc_pkg::MULT_CODE_X4, slpc_pkg::MULT_CODE_X5,
      slpc_pkg::MULT_CODE_X8P25, slpc_pkg::MULT_CODE_X10: mult_decode = c;
      default: mult_decode = 8'h00;
    endcase
  endfunction

  logic [3:0] nxt_rate_halves;

  always_comb begin
    unique case (rate_i)
      slpc_pkg::RATE_X4: nxt_rate_halves = 4'h8;
      slpc_pkg::RATE_X2: nxt_rate_halves = 4'h4;
      slpc_pkg::RATE_X1: nxt_rate_halves = 4'h2;
      slpc_pkg::RATE_XHALF: nxt_rate_halves = 4'h1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_quarters_o <= 8'h00;
      rate_halves_o <= 4'h0;
      cfg_legal_o <= 1'b0;
    end else if (cke_i) begin
      mult_quarters_o <= mult_decode(mult_code_i);
      rate_halves_o <= nxt_rate_halves;
      cfg_legal_o <= div_legal(ref_div_i) && (mult_decode(mult_code_i) != 8'h00);
    end
  end

  chk_mult_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    cke_i && mult_code_i == slpc_pkg::MULT_CODE_X8P25 |=> mult_quarters_o == 8'h21)
    else $error("multiplier code 0x21 not decoded to 33 quarters");
  chk_rate_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    cke_i |=> rate_halves_o == (4'h8 >> $past(rate_i)))
    else $error("line rate ratio wrong");
  chk_div_illegal: assert property (@(posedge clk_i) disable iff (rst_i)
    cke_i && ref_div_i == 6'h07 |=> !cfg_legal_o)
    else $error("divisor 7 reported legal");
endmodule

// >>> hdl/slpc_regs.sv
// Status and PLL configuration registers of the serial receive link.
// Assumes a byte register port from the serial control port front end and
// link events that are synchronous to MCLK_I.
`timescale 1ns/10ps

// Summary of operation
// - Buffer overrun sets bit 7, write-one clears
// - Bit 6 shows link up, buffer released
// - Bit 5 reads 0 while SYNC asserted
// - SYSREF realignment sets bit 4, write-one clears
// - Bit 3 shows last SYSREF consistent, read-only
// - Up to seven SYSREF pulses for alignment
// - Bit 2 high when all enabled PLLs lock, low if none enabled
// - Six-bit divisor forms PLL reference clock
// - Multiplier codes 10h,14h,21h,28h give 4,5,8.25,10
// - Two-bit line rate gives 4,2,1,0.5
// - Reset loads 30h, 14h and 00b
module slpc_regs (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CKE_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic ELASTIC_OVERRUN_I,
  input wire logic BUF_RELEASED_I,
  input wire logic SYNC_ASSERTED_I,
  input wire logic SYSREF_PULSE_I,
  input wire logic SYSREF_REALIGN_I,
  input wire logic SYSREF_CONSISTENT_I,
  input wire logic LINK_ENABLE_I,
  input wire logic [3:0] PLL_ENABLE_I,
  input wire logic [3:0] PLL_LOCK_I,
  output logic [5:0] REF_CLOCK_DIVISOR_O,
  output logic [7:0] PLL_MULTIPLIER_CODE_O,
  output logic [1:0] LINE_RATE_O,
  output logic [7:0] PLL_MULT_QUARTERS_O,
  output logic [3:0] LINE_RATE_HALVES_O,
  output logic CFG_LEGAL_O,
  output logic CFG_CHANGED_LIVE_O,
  output logic SYSREF_ALIGN_LATE_O
);
  logic elastic_overrun_flag_ff;
  logic realigned_ff;
  logic link_up_ff;
  logic sync_line_level_ff;
  logic sysref_consistent_ff;
  logic pll_locked_ff;
  logic [2:0] sysref_cnt_ff;
  logic link_enable_ff;
  logic [7:0] link_status_reg;
  logic [7:0] nxt_rdata;
  logic wr_status;
  logic wr_ref_div;
  logic wr_mult;
  logic wr_rate;

  assign wr_status = REG_WR_I && REG_ADDR_I == slpc_pkg::OFS_LINK_STATUS;
  assign wr_ref_div = REG_WR_I && REG_ADDR_I == slpc_pkg::OFS_REF_DIV;
  assign wr_mult = REG_WR_I && REG_ADDR_I == slpc_pkg::OFS_PLL_MULT;
  assign wr_rate = REG_WR_I && REG_ADDR_I == slpc_pkg::OFS_LINE_RATE;

  // Sticky flags: a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      elastic_overrun_flag_ff <= 1'b0;
      realigned_ff <= 1'b0;
    end else if (CKE_I) begin
      if (ELASTIC_OVERRUN_I) begin
        elastic_overrun_flag_ff <= 1'b1;
      end else if (wr_status && REG_WDATA_I[slpc_pkg::BIT_OVERRUN]) begin
        elastic_overrun_flag_ff <= 1'b0;
      end
      if (SYSREF_REALIGN_I) begin
        realigned_ff <= 1'b1;
      end else if (wr_status && REG_WDATA_I[slpc_pkg::BIT_REALIGNED]) begin
        realigned_ff <= 1'b0;
      end
    end
  end

  // Read-only status is sampled each cycle and ignores every write.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      link_up_ff <= 1'b0;
      sync_line_level_ff <= 1'b0;
      sysref_consistent_ff <= 1'b0;
      pll_locked_ff <= 1'b0;
    end else if (CKE_I) begin
      link_up_ff <= BUF_RELEASED_I;
      sync_line_level_ff <= !SYNC_ASSERTED_I;
      sysref_consistent_ff <= SYSREF_CONSISTENT_I;
      // No enabled PLL means nothing is locked, so the bit stays low.
      pll_locked_ff <= (|PLL_ENABLE_I) && ((PLL_LOCK_I & PLL_ENABLE_I) == PLL_ENABLE_I);
    end
  end

  // Count SYSREF pulses since link enable to flag a link still not consistent after seven of them.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sysref_cnt_ff <= 3'h0;
      link_enable_ff <= 1'b0;
    end else if (CKE_I) begin
      link_enable_ff <= LINK_ENABLE_I;
      if (!LINK_ENABLE_I) begin
        sysref_cnt_ff <= 3'h0;
      end else if (SYSREF_PULSE_I && sysref_cnt_ff != slpc_pkg::SYSREF_ALIGN_MAX) begin
        sysref_cnt_ff <= sysref_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      SYSREF_ALIGN_LATE_O <= 1'b0;
    end else if (CKE_I) begin
      SYSREF_ALIGN_LATE_O <= link_enable_ff && sysref_cnt_ff == slpc_pkg::SYSREF_ALIGN_MAX
                             && !sysref_consistent_ff;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      REF_CLOCK_DIVISOR_O <= slpc_pkg::RST_REF_DIV;
      PLL_MULTIPLIER_CODE_O <= slpc_pkg::RST_PLL_MULT;
      LINE_RATE_O <= slpc_pkg::RST_LINE_RATE;
    end else if (CKE_I) begin
      if (wr_ref_div) begin
        REF_CLOCK_DIVISOR_O <= REG_WDATA_I[slpc_pkg::REF_DIV_W-1:0];
      end
      if (wr_mult) begin
        PLL_MULTIPLIER_CODE_O <= REG_WDATA_I;
      end
      if (wr_rate) begin
        LINE_RATE_O <= REG_WDATA_I[slpc_pkg::RATE_W-1:0];
      end
    end
  end

  // Software should not change the multiplier or line rate while the link runs; this only reports it, the write still lands.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      CFG_CHANGED_LIVE_O <= 1'b0;
    end else if (CKE_I) begin
      if (LINK_ENABLE_I && (wr_mult || wr_rate)) begin
        CFG_CHANGED_LIVE_O <= 1'b1;
      end else if (!LINK_ENABLE_I) begin
        CFG_CHANGED_LIVE_O <= 1'b0;
      end
    end
  end

  always_comb begin
    link_status_reg = 8'h00;
    link_status_reg[slpc_pkg::BIT_OVERRUN] = elastic_overrun_flag_ff;
    link_status_reg[slpc_pkg::BIT_LINK_UP] = link_up_ff;
    link_status_reg[slpc_pkg::BIT_SYNC_LEVEL] = sync_line_level_ff;
    link_status_reg[slpc_pkg::BIT_REALIGNED] = realigned_ff;
    link_status_reg[slpc_pkg::BIT_CONSISTENT] = sysref_consistent_ff;
    link_status_reg[slpc_pkg::BIT_PLL_LOCKED] = pll_locked_ff;
  end

  always_comb begin
    unique case (REG_ADDR_I)
      slpc_pkg::OFS_LINK_STATUS: nxt_rdata = link_status_reg;
      slpc_pkg::OFS_REF_DIV: nxt_rdata = {2'h0, REF_CLOCK_DIVISOR_O};
      slpc_pkg::OFS_PLL_MULT: nxt_rdata = PLL_MULTIPLIER_CODE_O;
      slpc_pkg::OFS_LINE_RATE: nxt_rdata = {6'h00, LINE_RATE_O};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Reads only capture data; no flag changes on a read.
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else if (CKE_I) begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= nxt_rdata;
      end
    end
  end

  slpc_cfg_decode u_decode (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .cke_i(CKE_I),
    .ref_div_i(REF_CLOCK_DIVISOR_O),
    .mult_code_i(PLL_MULTIPLIER_CODE_O),
    .rate_i(LINE_RATE_O),
    .mult_quarters_o(PLL_MULT_QUARTERS_O),
    .rate_halves_o(LINE_RATE_HALVES_O),
    .cfg_legal_o(CFG_LEGAL_O)
  );

  chk_overrun_sets: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && ELASTIC_OVERRUN_I |=> elastic_overrun_flag_ff)
    else $error("overrun event did not set flag");
  chk_overrun_holds: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && elastic_overrun_flag_ff && !(wr_status && REG_WDATA_I[slpc_pkg::BIT_OVERRUN])
    |=> elastic_overrun_flag_ff)
    else $error("overrun flag dropped without write-one");
  chk_realign_clear: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && wr_status && REG_WDATA_I[slpc_pkg::BIT_REALIGNED] && !SYSREF_REALIGN_I |=> !realigned_ff)
    else $error("realigned flag not cleared");
  chk_link_up: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I |=> link_up_ff == $past(BUF_RELEASED_I))
    else $error("link up bit does not follow buffer release");
  chk_sync_level: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && SYNC_ASSERTED_I |=> !link_status_reg[slpc_pkg::BIT_SYNC_LEVEL])
    else $error("sync bit high while sync asserted");
  chk_consistent_ro: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && SYSREF_CONSISTENT_I ##1 CKE_I && wr_status && SYSREF_CONSISTENT_I |=> sysref_consistent_ff)
    else $error("consistency bit changed by write");
  chk_pll_lock: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && (PLL_ENABLE_I & ~PLL_LOCK_I) != 4'h0 |=> !pll_locked_ff)
    else $error("lock reported with an enabled PLL unlocked");
  chk_sysref_sat: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && LINK_ENABLE_I && SYSREF_PULSE_I && sysref_cnt_ff == 3'h6 |=> sysref_cnt_ff == 3'h7
    ##1 (!CKE_I || sysref_cnt_ff == 3'h7 || !LINK_ENABLE_I))
    else $error("sysref pulse counter wrong near saturation");
  chk_reset_vals: assert property (@(posedge MCLK_I)
    RESET_I |=> REF_CLOCK_DIVISOR_O == 6'h30 && PLL_MULTIPLIER_CODE_O == 8'h14 && LINE_RATE_O == 2'h0)
    else $error("configuration reset values wrong");
  chk_read_data: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && REG_RD_I && REG_ADDR_I == slpc_pkg::OFS_PLL_MULT && !wr_mult
    |=> REG_RVALID_O && REG_RDATA_O == PLL_MULTIPLIER_CODE_O)
    else $error("multiplier readback wrong");
  chk_live_change: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && LINK_ENABLE_I && wr_rate |=> CFG_CHANGED_LIVE_O)
    else $error("live rate change not reported");

  cov_overrun_clear: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    elastic_overrun_flag_ff ##1 CKE_I && wr_status && REG_WDATA_I[7] ##1 !elastic_overrun_flag_ff);
  cov_set_wins: cover property (@(posedge MCLK_I) disable iff (RESET_I)
    CKE_I && wr_status && REG_WDATA_I[4] && SYSREF_REALIGN_I);
  cov_align_late: cover property (@(posedge MCLK_I) disable iff (RESET_I) SYSREF_ALIGN_LATE_O);
endmodule

// >>> sim/slpc_link_model.sv
// Link-side model: SYSREF source, elastic buffer events and SerDes PLL locks.
// Assumes bench requests that change on the falling edge of clk_i.
`timescale 1ns/10ps
module slpc_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_enable_i,
  input wire logic sysref_req_i,
  input wire logic overrun_req_i,
  input wire logic [3:0] need_i,
  input wire logic [3:0] pll_en_i,
  input wire logic [3:0] pll_fault_i,
  output logic sysref_o,
  output logic realign_o,
  output logic consistent_o,
  output logic overrun_o,
  output logic [3:0] pll_lock_o
);
  logic [3:0] cnt_ff;
  // A faulty PLL loses lock when enabled and shows stray lock when disabled.
  always_ff @(posedge clk_i) begin
    sysref_o <= sysref_req_i & ~rst_i;
    overrun_o <= overrun_req_i & ~rst_i;
    pll_lock_o <= pll_en_i ^ pll_fault_i;
  end
  // Alignment needs need_i pulses after enable, so values above 7 need more than a seven-pulse burst.
  always_ff @(posedge clk_i) begin
    if (rst_i || !link_enable_i) begin
      cnt_ff <= 4'h0;
      realign_o <= 1'b0;
      consistent_o <= 1'b0;
    end else begin
      realign_o <= sysref_req_i & ~consistent_o;
      if (sysref_req_i) begin
        cnt_ff <= cnt_ff + 4'h1;
        consistent_o <= (cnt_ff + 4'h1) >= need_i;
      end
    end
  end
endmodule

// >>> sim/serial_link_status_pll_config_test.sv
// Self-checking bench for the link status and PLL configuration registers.
// Assumes slpc_regs as the device and slpc_link_model on the link side.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module serial_link_status_pll_config_test;
  localparam logic [15:0] ST = 16'h0107, DV = 16'h0108, MU = 16'h0109, RT = 16'h010a;
  logic clk = 1'b0, rst = 1'b1, cke = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sref = 1'b0, ovr = 1'b0;
  logic rvalid, released = 1'b0, sync_a = 1'b0, link_en = 1'b0;
  logic m_sref, m_rl, m_cons, m_ovr, legal, live, late;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, q8, multo, quart;
  logic [3:0] need = 4'h7, pll_en = 4'h0, pll_fault = 4'h0, m_lock, halves;
  logic [5:0] divo;
  logic [1:0] rateo;
  logic [31:0] lf = 32'd80392;
  logic [7:0] exp_q[$];
  // Quarter units of the multiplier happen to equal the codes themselves.
  logic [7:0] mc[4] = '{8'h10, 8'h14, 8'h21, 8'h28};
  logic [3:0] hv[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [5:0] dl[14] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20,
    6'h28, 6'h30};
  int error_cnt = 0, compares = 0, cyc = 0;

  slpc_regs i_slpc_regs (
    .MCLK_I(clk), .RESET_I(rst), .CKE_I(cke), .REG_ADDR_I(addr), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .ELASTIC_OVERRUN_I(m_ovr),
    .BUF_RELEASED_I(released), .SYNC_ASSERTED_I(sync_a), .SYSREF_PULSE_I(m_sref), .SYSREF_REALIGN_I(m_rl),
    .SYSREF_CONSISTENT_I(m_cons), .LINK_ENABLE_I(link_en), .PLL_ENABLE_I(pll_en), .PLL_LOCK_I(m_lock),
    .REF_CLOCK_DIVISOR_O(divo), .PLL_MULTIPLIER_CODE_O(multo), .LINE_RATE_O(rateo), .PLL_MULT_QUARTERS_O(quart),
    .LINE_RATE_HALVES_O(halves), .CFG_LEGAL_O(legal), .CFG_CHANGED_LIVE_O(live), .SYSREF_ALIGN_LATE_O(late)
  );
  slpc_link_model i_slpc_link_model (
    .clk_i(clk), .rst_i(rst), .link_enable_i(link_en), .sysref_req_i(sref), .overrun_req_i(ovr),
    .need_i(need), .pll_en_i(pll_en), .pll_fault_i(pll_fault), .sysref_o(m_sref), .realign_o(m_rl),
    .consistent_o(m_cons), .overrun_o(m_ovr), .pll_lock_o(m_lock)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Flags in f are overrun, realigned and consistent; the rest follow the link levels.
  function automatic logic [7:0] stat(input logic [2:0] f);
    return {f[2], released, ~sync_a, f[1], f[0], (pll_en != 4'h0) && ((pll_en & pll_fault) == 4'h0), 2'b00};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd_s = 1'b0;
  endtask
  task automatic burst();
    repeat (7) begin
      @(negedge clk);
      sref = 1'b1;
      @(negedge clk);
      sref = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      q8 = (exp_q.size() == 0) ? 8'hxx : exp_q.pop_front();
      `CHK(rdata, q8)
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd(DV, 8'h30);
    rd(MU, 8'h14);
    rd(RT, 8'h00);
    rd(16'h010b, 8'h00);
    rd(ST, stat(3'b000));
    @(negedge clk);
    ovr = 1'b1;
    @(negedge clk);
    ovr = 1'b0;
    repeat (2) @(negedge clk);
    rd(ST, stat(3'b100));
    wr(ST, 8'h7f);
    rd(ST, stat(3'b100));
    rd(ST, stat(3'b100));
    wr(ST, 8'h80);
    rd(ST, stat(3'b000));
    // The overrun event reaches the device in the same cycle as the clear, and the set must win.
    ovr = 1'b1;
    fork
      wr(ST, 8'h80);
      begin
        @(negedge clk);
        ovr = 1'b0;
      end
    join
    rd(ST, stat(3'b100));
    wr(ST, 8'h80);
    rd(ST, stat(3'b000));
    for (int i = 0; i < 4; i++) begin
      {released, sync_a} = i[1:0];
      repeat (2) @(negedge clk);
      rd(ST, stat(3'b000));
    end
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      pll_en = lf[3:0];
      pll_fault = lf[7:4] & {4{lf[8]}};
      repeat (3) @(negedge clk);
      rd(ST, stat(3'b000));
    end
    need = 4'h8;
    link_en = 1'b1;
    burst();
    `CHK(late, 1'b1)
    rd(ST, stat(3'b010));
    wr(ST, 8'h10);
    rd(ST, stat(3'b000));
    link_en = 1'b0;
    need = 4'h7;
    repeat (3) @(negedge clk);
    `CHK(late, 1'b0)
    link_en = 1'b1;
    burst();
    `CHK(late, 1'b0)
    rd(ST, stat(3'b011));
    wr(ST, 8'h18);
    rd(ST, stat(3'b001));
    wr(MU, 8'h21);
    repeat (2) @(negedge clk);
    `CHK(live, 1'b1)
    link_en = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(live, 1'b0)
    for (int i = 0; i < 4; i++) begin
      wr(MU, mc[i]);
      rd(MU, mc[i]);
      `CHK(quart, mc[i])
      `CHK(multo, mc[i])
      lf = nxt(lf);
      wr(RT, {lf[5:0], i[1:0]});
      rd(RT, {6'h00, i[1:0]});
      `CHK(halves, hv[i])
      `CHK(rateo, i[1:0])
    end
    for (int i = 0; i < 14; i++) begin
      wr(DV, {2'b11, dl[i]});
      rd(DV, {2'b00, dl[i]});
      `CHK(legal, 1'b1)
      `CHK(divo, dl[i])
    end
    wr(DV, 8'h07);
    rd(DV, 8'h07);
    `CHK(legal, 1'b0)
    wr(DV, 8'h30);
    wr(MU, 8'h15);
    repeat (2) @(negedge clk);
    `CHK(legal, 1'b0)
    `CHK(quart, 8'h00)
    cke = 1'b0;
    wr(DV, 8'h02);
    cke = 1'b1;
    rd(DV, 8'h30);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(MU, 8'h14);
    rd(RT, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
